// >>> emfs_pkg.sv
// Purpose: shared constants and types for the multiframe alignment and error-level block
// Assumes: byte stream of 32-byte link frames, 8 blocks per superblock, 3 superblocks per multiframe
// Notes: register offsets are byte addresses on the AXI4-Lite slave
package emfs_pkg;
  localparam logic [7:0] SYNC_BYTE = 8'h1b;
  localparam int FRAME_LEN = 32;
  localparam logic [4:0] SYNC_POS = 5'h00;
  localparam logic [4:0] SIG_POS = 5'h10;
  localparam logic [4:0] MGMT_POS = 5'h01;
  localparam int LOSS_COUNT = 3;
  localparam int BLK_PER_SB = 8;
  localparam int SB_PER_MF = 3;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_ERR = 8'h08;
  // control fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_ERR_LSB = 1;
  localparam logic [2:0] CTRL_RESET = 3'h1;
  typedef enum {ST_HUNT, ST_MISS, ST_CONFIRM, ST_LOCKED} emfs_fa_t;
  typedef struct packed {
    logic crc_sub;
    logic corrected;
    logic crc_hdr;
    logic uncorrected;
    logic dfs_zero;
  } emfs_chk_t;
  typedef struct packed {
    logic frame_lock;
    logic mf_lock;
    logic decode;
    logic [1:0] err_level;
  } emfs_stat_t;
endpackage : emfs_pkg

// >>> emfs_err_merge.sv
// Purpose: combine recovered and locally detected error levels
// Assumes: all inputs on the link clock
// Notes: output registered
`timescale 1ns/1ps
module emfs_err_merge (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [1:0] rec_level,
  input wire emfs_pkg::emfs_chk_t chk,
  input wire logic aligned,
  input wire logic strobe,
  output logic [1:0] level_q
);
  logic [1:0] loc;
  logic [1:0] base;
  always_comb begin
    loc = 2'h0;
    if (chk.crc_sub || chk.corrected) loc = 2'h1;
    if (chk.crc_hdr || chk.uncorrected) loc = 2'h2;
    if (!aligned) loc = 2'h3;
    // no data field: recovered level carries no meaning
    base = chk.dfs_zero ? 2'h0 : rec_level;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= 2'h3;
    end else if (strobe) begin
      level_q <= (loc > base) ? loc : base;
    end
  end
endmodule : emfs_err_merge

// >>> emfs_align.sv
// Purpose: frame and multiframe alignment with error-level update, AXI4-Lite control
// Assumes: byte stream arrives on link clock with a byte strobe; checks arrive per multiframe
// Notes: link logic on LINK_CLK; status crosses via two-flop synchronisers
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module emfs_align #(
  parameter int MGMT_LSB = 5
) (
  // system
  input wire logic CLK,
  input wire logic RSTN,
  // link side
  input wire logic LINK_CLK,
  input wire logic LINK_BYTE_VALID,
  input wire logic [7:0] LINK_BYTE,
  input wire emfs_pkg::emfs_chk_t LINK_CHK,
  input wire logic LINK_CHK_VALID,
  output logic DECODE_ENABLE,
  output logic [1:0] ERR_LEVEL,
  // axi4-lite write
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  ////////////////////////////////////////////////////////////////////////
  // resets
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end
  logic lrst_s1_q, lrst_n_q;
  always_ff @(posedge LINK_CLK or negedge RSTN) begin
    if (!RSTN) begin
      lrst_s1_q <= 1'b0;
      lrst_n_q <= 1'b0;
    end else begin
      lrst_s1_q <= 1'b1;
      lrst_n_q <= lrst_s1_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // control crossing into the link domain
  logic [2:0] ctrl_q;
  logic [2:0] lctrl_s1_q, lctrl_s2_q, lctrl_s3_q, lctrl_q;
  // multi-bit word: taken only when two samples past the synchroniser agree, so a torn capture never lands
  always_ff @(posedge LINK_CLK or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      lctrl_s1_q <= emfs_pkg::CTRL_RESET;
      lctrl_s2_q <= emfs_pkg::CTRL_RESET;
      lctrl_s3_q <= emfs_pkg::CTRL_RESET;
      lctrl_q <= emfs_pkg::CTRL_RESET;
    end else begin
      lctrl_s1_q <= ctrl_q;
      lctrl_s2_q <= lctrl_s1_q;
      lctrl_s3_q <= lctrl_s2_q;
      if (lctrl_s2_q == lctrl_s3_q) begin
        lctrl_q <= lctrl_s3_q;
      end
    end
  end
  logic enable;
  assign enable = lctrl_q[emfs_pkg::CTRL_ENABLE];
  ////////////////////////////////////////////////////////////////////////
  // frame alignment, link domain
  emfs_pkg::emfs_fa_t fa_q;
  logic [4:0] pos_q;
  logic [1:0] bad_q;
  logic nsf_q;
  logic is_sync;
  logic frame_lock;
  assign is_sync = LINK_BYTE == emfs_pkg::SYNC_BYTE;
  assign frame_lock = fa_q == emfs_pkg::ST_LOCKED;
  // byte index inside the frame; resynced while hunting
  always_ff @(posedge LINK_CLK or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      pos_q <= 5'h00;
    end else if (LINK_BYTE_VALID) begin
      if (fa_q == emfs_pkg::ST_HUNT && is_sync) begin
        pos_q <= 5'h01;
      end else begin
        pos_q <= pos_q + 5'h01;
      end
    end
  end
  // timeslot zero bit 1 in the non-sync frame sits in the byte at position 0
  always_ff @(posedge LINK_CLK or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      fa_q <= emfs_pkg::ST_HUNT;
      bad_q <= 2'h0;
      nsf_q <= 1'b0;
    end else if (!enable) begin
      fa_q <= emfs_pkg::ST_HUNT;
      bad_q <= 2'h0;
      nsf_q <= 1'b0;
    end else if (LINK_BYTE_VALID && pos_q == emfs_pkg::SYNC_POS) begin
      case (fa_q)
        emfs_pkg::ST_HUNT: begin
          fa_q <= is_sync ? emfs_pkg::ST_MISS : emfs_pkg::ST_HUNT;
        end
        emfs_pkg::ST_MISS: begin
          fa_q <= (!is_sync && LINK_BYTE[1]) ? emfs_pkg::ST_CONFIRM : emfs_pkg::ST_HUNT;
        end
        emfs_pkg::ST_CONFIRM: begin
          fa_q <= is_sync ? emfs_pkg::ST_LOCKED : emfs_pkg::ST_HUNT;
          bad_q <= 2'h0;
          // frame after a sync frame carries no sync byte
          nsf_q <= 1'b1;
        end
        default: begin
          // only sync-carrying frames count towards loss
          nsf_q <= !nsf_q;
          if (!nsf_q && is_sync) begin
            bad_q <= 2'h0;
          end else if (!nsf_q && bad_q == 2'(emfs_pkg::LOSS_COUNT - 1)) begin
            fa_q <= emfs_pkg::ST_HUNT;
            bad_q <= 2'h0;
          end else if (!nsf_q) begin
            bad_q <= bad_q + 2'h1;
          end
        end
      endcase
    end else if (LINK_BYTE_VALID && fa_q == emfs_pkg::ST_HUNT && is_sync) begin
      fa_q <= emfs_pkg::ST_MISS;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // multiframe alignment, link domain
  logic mgmt_hit;
  logic [2:0] blk_now, sb_now;
  assign mgmt_hit = frame_lock && LINK_BYTE_VALID && pos_q == emfs_pkg::MGMT_POS;
  assign blk_now = LINK_BYTE[2:0];
  assign sb_now = {1'b0, LINK_BYTE[4:3]};
  // history of block counts over the last 16 frames
  logic [2:0] hist_q [16];
  logic [4:0] fcnt_q;
  logic [4:0] good_q;
  logic mf_lock_q;
  logic [1:0] mbad_q;
  logic step8, step16;
  assign step8 = blk_now == hist_q[7] + 3'h1;
  assign step16 = hist_q[7] == hist_q[15] + 3'h1;
  always_ff @(posedge LINK_CLK) begin
    if (mgmt_hit) begin
      hist_q[0] <= blk_now;
    end
  end
  genvar gi;
  generate
    for (gi = 1; gi < 16; gi++) begin : g_hist
      always_ff @(posedge LINK_CLK) begin
        if (mgmt_hit) begin
          hist_q[gi] <= hist_q[gi - 1];
        end
      end
    end
  endgenerate
  always_ff @(posedge LINK_CLK or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      fcnt_q <= 5'h00;
      good_q <= 5'h00;
      mf_lock_q <= 1'b0;
      mbad_q <= 2'h0;
    end else if (!frame_lock) begin
      fcnt_q <= 5'h00;
      good_q <= 5'h00;
      mf_lock_q <= 1'b0;
      mbad_q <= 2'h0;
    end else if (mgmt_hit) begin
      if (fcnt_q != 5'h10) begin
        fcnt_q <= fcnt_q + 5'h01;
      end
      if (!mf_lock_q) begin
        // need 16 fresh frames of history; older entries predate this lock
        if (fcnt_q == 5'h10 && step8 && step16) begin
          good_q <= good_q + 5'h01;
          if (good_q == 5'(emfs_pkg::BLK_PER_SB - 1)) begin
            mf_lock_q <= 1'b1;
          end
        end else begin
          good_q <= 5'h00;
        end
      end else if (step8) begin
        mbad_q <= 2'h0;
      end else if (mbad_q == 2'(emfs_pkg::LOSS_COUNT - 1)) begin
        mf_lock_q <= 1'b0;
        good_q <= 5'h00;
        mbad_q <= 2'h0;
      end else begin
        mbad_q <= mbad_q + 2'h1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // decoding start and recovered level
  logic decode_q;
  logic [1:0] rec_q;
  logic mf_start;
  // first block of superblock 0 marks a multiframe boundary
  assign mf_start = mgmt_hit && blk_now == 3'h0 && sb_now == 3'h0;
  always_ff @(posedge LINK_CLK or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      decode_q <= 1'b0;
    end else if (!mf_lock_q) begin
      decode_q <= 1'b0;
    end else if (mf_start) begin
      decode_q <= 1'b1;
    end
  end
  always_ff @(posedge LINK_CLK or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      rec_q <= 2'h0;
    end else if (mgmt_hit && decode_q) begin
      rec_q <= LINK_BYTE[MGMT_LSB +: 2];
    end
  end
  logic [1:0] level;
  logic aligned;
  assign aligned = mf_lock_q && decode_q;
  emfs_err_merge u_merge (
    .clk(LINK_CLK),
    .rst_n(lrst_n_q),
    .rec_level(rec_q),
    .chk(LINK_CHK),
    .aligned(aligned),
    .strobe(LINK_CHK_VALID),
    .level_q(level)
  );
  logic [1:0] floor_lvl;
  assign floor_lvl = lctrl_q[emfs_pkg::CTRL_ERR_LSB +: 2];
  always_ff @(posedge LINK_CLK or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      DECODE_ENABLE <= 1'b0;
      ERR_LEVEL <= 2'h3;
    end else begin
      DECODE_ENABLE <= decode_q;
      // software floor can only raise, never lower
      ERR_LEVEL <= (floor_lvl > level) ? floor_lvl : level;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // status crossing into the bus domain
  emfs_pkg::emfs_stat_t lstat, lstat_q;
  assign lstat = '{frame_lock: frame_lock, mf_lock: mf_lock_q, decode: decode_q, err_level: level};
  // launched from a flop so no decode glitch is captured
  always_ff @(posedge LINK_CLK or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      lstat_q <= 5'h00;
    end else begin
      lstat_q <= lstat;
    end
  end
  logic [4:0] stat_s1_q, stat_s2_q, stat_s3_q, stat_q;
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      stat_s1_q <= 5'h00;
      stat_s2_q <= 5'h00;
      stat_s3_q <= 5'h00;
      stat_q <= 5'h00;
    end else begin
      stat_s1_q <= lstat_q;
      stat_s2_q <= stat_s1_q;
      stat_s3_q <= stat_s2_q;
      // two agreeing samples: the level bits cannot tear
      if (stat_s2_q == stat_s3_q) begin
        stat_q <= stat_s3_q;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic aw_have_q, w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= 2'h0;
      ctrl_q <= emfs_pkg::CTRL_RESET;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_have_q <= 1'b1;
        awaddr_q <= AWADDR;
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_have_q <= 1'b1;
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
        WREADY <= 1'b0;
      end
      if (aw_have_q && w_have_q && !BVALID) begin
        BVALID <= 1'b1;
        if (awaddr_q == emfs_pkg::REG_CTRL) begin
          BRESP <= 2'h0;
          if (wstrb_q[0]) begin
            ctrl_q <= wdata_q[2:0];
          end
        end else if (awaddr_q == emfs_pkg::REG_STAT || awaddr_q == emfs_pkg::REG_ERR) begin
          BRESP <= 2'h0;
        end else begin
          BRESP <= 2'h2;
        end
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= 2'h0;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RRESP <= 2'h0;
      if (ARADDR == emfs_pkg::REG_CTRL) begin
        RDATA <= {29'h0, ctrl_q};
      end else if (ARADDR == emfs_pkg::REG_STAT) begin
        RDATA <= {27'h0, stat_q};
      end else if (ARADDR == emfs_pkg::REG_ERR) begin
        RDATA <= {30'h0, stat_q[1:0]};
      end else begin
        RDATA <= 32'h0;
        RRESP <= 2'h2;
      end
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
      ARREADY <= 1'b1;
    end
  end
endmodule : emfs_align

// >>> emfs_align_props.sv
// Purpose: port checks for the alignment block, bus handshakes and error levels
// Assumes: bus on CLK, stream and levels on LINK_CLK
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module emfs_align_props (
  // clocks and reset
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic LINK_CLK,
  // link
  input wire logic [7:0] LINK_BYTE,
  input wire emfs_pkg::emfs_chk_t LINK_CHK,
  input wire logic LINK_CHK_VALID,
  input wire logic DECODE_ENABLE,
  input wire logic [1:0] ERR_LEVEL,
  // bus
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic RVALID,
  input wire logic RREADY
);
  sequence wr_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence rd_taken;
    ARVALID && ARREADY;
  endsequence
  ////////////////////////////////////////
  wr_answer_a: assert property (@(posedge CLK) disable iff (!RSTN) wr_taken |-> ##2 BVALID)
    else $error("write response missing");
  b_hold_a: assert property (@(posedge CLK) disable iff (!RSTN) BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  b_block_a: assert property (@(posedge CLK) disable iff (!RSTN) BVALID |-> !AWREADY && !WREADY)
    else $error("new write taken while answering");
  rd_answer_a: assert property (@(posedge CLK) disable iff (!RSTN) rd_taken |=> RVALID && !ARREADY)
    else $error("read response missing");
  r_hold_a: assert property (@(posedge CLK) disable iff (!RSTN) RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  sub_level_a: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    LINK_CHK_VALID && (LINK_CHK.crc_sub || LINK_CHK.corrected) |-> ##[1:2] ERR_LEVEL >= 2'h1)
    else $error("level not raised to one");
  hdr_level_a: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    LINK_CHK_VALID && (LINK_CHK.crc_hdr || LINK_CHK.uncorrected) |-> ##[1:2] ERR_LEVEL >= 2'h2)
    else $error("level not raised to two");
  // block 0 superblock 0 byte must precede the start of decoding
  dec_start_a: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
    $rose(DECODE_ENABLE) |-> $past(LINK_BYTE[4:0], 2) == 5'h00 || $past(LINK_BYTE[4:0], 3) == 5'h00)
    else $error("decoding started off a multiframe boundary");
endmodule : emfs_align_props

bind emfs_align emfs_align_props u_emfs_align_props (.CLK(CLK), .RSTN(RSTN), .LINK_CLK(LINK_CLK),
  .LINK_BYTE(LINK_BYTE), .LINK_CHK(LINK_CHK), .LINK_CHK_VALID(LINK_CHK_VALID), .DECODE_ENABLE(DECODE_ENABLE),
  .ERR_LEVEL(ERR_LEVEL), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
  .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID),
  .RREADY(RREADY));

// >>> emfs_tx_model.sv
// Purpose: transmitting end of the link, framed byte stream with management bytes
// Assumes: one byte per link clock, no gaps
// Notes: odd frames carry the non-sync word so the frame search can confirm
`timescale 1ns/1ps
module emfs_tx_model #(
  parameter int MGMT_LSB = 5
) (
  // link clock
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic [1:0] level,
  input wire logic bad_sync,
  // stream
  output logic byte_valid,
  output logic [7:0] byte_q
);
  logic [4:0] pos_q;
  logic [7:0] frame_q;
  assign byte_valid = rst_n;
  ////////////////////////////////////////
  // 192 frames: 8 frames per block, 8 blocks, 3 superblocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_q <= 5'h00;
      frame_q <= 8'h00;
    end else begin
      pos_q <= pos_q + 5'h01;
      if (pos_q == 5'h1f) begin
        frame_q <= (frame_q == 8'hbf) ? 8'h00 : frame_q + 8'h01;
      end
    end
  end
  always_comb begin
    byte_q = {3'h0, pos_q} ^ frame_q;
    if (pos_q == 5'h00) begin
      byte_q = bad_sync ? 8'h00 : (frame_q[0] ? 8'h42 : emfs_pkg::SYNC_BYTE);
    end
    if (pos_q == 5'h01) begin
      byte_q = (8'(level) << MGMT_LSB) | {3'h0, frame_q[7:6], frame_q[5:3]};
    end
    if (pos_q == 5'h10) begin
      byte_q = 8'h00;
    end
  end
endmodule : emfs_tx_model

// >>> e1_multiframe_sync_err_update_bench.sv
// Purpose: self-checking bench for the alignment block
// Assumes: bus clock 100 ns, link clock 80 ns free running
// Notes: link levels are set, then one check pulse judges the merged level
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module e1_multiframe_sync_err_update_bench;
  logic clk, lclk, bv, dec, awr, wr, bvld, arr, rvld;
  logic rstn = 1'b0, tx_rstn = 1'b0, cv = 1'b0, bad = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0;
  logic arv = 1'b0, rrdy = 1'b0;
  logic [7:0] lbyte;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [1:0] lvl = 2'h0;
  logic [1:0] bresp, rresp, err;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  emfs_pkg::emfs_chk_t chk = '0;
  int n_fail = 0;
  int n_tests = 0;
  emfs_align u_emfs_align (.CLK(clk), .RSTN(rstn), .LINK_CLK(lclk), .LINK_BYTE_VALID(bv), .LINK_BYTE(lbyte),
    .LINK_CHK(chk), .LINK_CHK_VALID(cv), .DECODE_ENABLE(dec), .ERR_LEVEL(err), .AWADDR(awa), .AWVALID(awv),
    .AWREADY(awr), .WDATA(wd), .WSTRB(4'hf), .WVALID(wv), .WREADY(wr), .BRESP(bresp), .BVALID(bvld),
    .BREADY(brdy), .ARADDR(ara), .ARVALID(arv), .ARREADY(arr), .RDATA(rdat), .RRESP(rresp), .RVALID(rvld),
    .RREADY(rrdy));
  emfs_tx_model u_emfs_tx_model (.clk(lclk), .rst_n(tx_rstn), .level(lvl), .bad_sync(bad), .byte_valid(bv),
    .byte_q(lbyte));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // odd offset keeps the two clocks out of phase
  initial begin
    lclk = 1'b0;
    #13;
    forever #40 lclk = ~lclk;
  end
  ////////////////////////////////////////
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bvld && n < 100);
    brdy <= 1'b0;
    `CHK(bresp, er)
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arr) arv <= 1'b0;
    end while (!rvld && n < 100);
    rrdy <= 1'b0;
    `CHK(rresp, er)
    `CHK(rdat, ev)
  endtask : axr
  // recovered level needs a full frame to reach the management byte
  task automatic lv(input emfs_pkg::emfs_chk_t c, input logic [1:0] rec, input logic [1:0] exp);
    @(posedge lclk);
    lvl <= rec;
    repeat (40) @(posedge lclk);
    chk <= c;
    cv <= 1'b1;
    @(posedge lclk);
    cv <= 1'b0;
    repeat (4) @(posedge lclk);
    `CHK(err, exp)
  endtask : lv
  task automatic wait_dec(input logic v);
    int n;
    n = 0;
    while (dec !== v && n < 30000) begin
      @(posedge lclk);
      n++;
    end
    `CHK(dec, v)
  endtask : wait_dec
  ////////////////////////////////////////
  task automatic t_reset;
    `CHK(err, 2'h3)
    `CHK(dec, 1'b0)
    axr(emfs_pkg::REG_CTRL, 32'h1, 2'h0);
    axr(8'h0c, 32'h0, 2'h2);
    axw(8'h0c, 32'h0, 2'h2);
    axw(emfs_pkg::REG_STAT, 32'h1f, 2'h0);
  endtask : t_reset
  task automatic t_lock;
    wait_dec(1'b1);
    lv('0, 2'h1, 2'h1);
    // status needs a few bus cycles to cross
    repeat (4) @(posedge clk);
    axr(emfs_pkg::REG_STAT, 32'h1d, 2'h0);
  endtask : t_lock
  task automatic t_levels;
    lv(5'h10, 2'h0, 2'h1);
    lv(5'h08, 2'h0, 2'h1);
    lv(5'h04, 2'h1, 2'h2);
    lv(5'h02, 2'h0, 2'h2);
    lv(5'h10, 2'h2, 2'h2);
    lv(5'h00, 2'h3, 2'h3);
    lv(5'h01, 2'h3, 2'h0);
    // software floor of 2 lifts a zero level
    axw(emfs_pkg::REG_CTRL, 32'h5, 2'h0);
    repeat (8) @(posedge lclk);
    `CHK(err, 2'h2)
    axr(emfs_pkg::REG_CTRL, 32'h5, 2'h0);
  endtask : t_levels
  task automatic t_ctrl;
    axw(emfs_pkg::REG_CTRL, 32'h0, 2'h0);
    wait_dec(1'b0);
    lv('0, 2'h0, 2'h3);
    axw(emfs_pkg::REG_CTRL, 32'h1, 2'h0);
    wait_dec(1'b1);
  endtask : t_ctrl
  // 60 link cycles hold at most two bad sync slots
  task automatic t_loss;
    @(posedge lclk);
    bad <= 1'b1;
    repeat (60) @(posedge lclk);
    `CHK(dec, 1'b1)
    wait_dec(1'b0);
    lv('0, 2'h0, 2'h3);
  endtask : t_loss
  task automatic test_done;
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  initial begin
    #6000000;
    n_fail++;
    test_done;
  end
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    @(posedge lclk);
    tx_rstn <= 1'b1;
    t_reset;
    t_lock;
    t_levels;
    t_ctrl;
    t_loss;
    test_done;
  end
endmodule : e1_multiframe_sync_err_update_bench
